/* hdl/psc_phase_ctrl.sv */
/*
 Control front end of a 6-bit phase shifter: pin synchronisers,
 serial/parallel selection, latch commit and an AXI4-Lite slave.
 Assumes SYS_CLK at 200 MHz; shift clock arrives on a shared pin.
*/
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.svh"

// ------------------------------------------------------------------
// Overview of operation
// - Select high means serial mode; shared pins are strobe, clock, data.
// - Select low disables serial path; shared pins are the three low bits.
// - Parallel mode applies the six control inputs with no latching stage.
// - Rising latch strobe moves the shifted word into the phase state.
// - Shift clock edges are ignored while the latch strobe is high.
// - Serial output equals serial input delayed six shift clock edges.
// - In serial mode the phase holds while the strobe stays low.
// - Phase is a 6-bit binary code, step 5.625 degrees, zero is reference.
// - Lowest bit weighs 5.625 degrees, each doubles, top bit 180 degrees.
// ------------------------------------------------------------------

module psc_phase_ctrl
   import psc_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RESET,
   input  wire logic        PAR_SER_SEL,
   input  wire logic        SERIAL_DATA_IN_OR_PHASE_BIT_LSB,
   input  wire logic        SHIFT_CLK_OR_PHASE_BIT_11P25,
   input  wire logic        LATCH_STROBE_OR_PHASE_BIT_22P5,
   input  wire logic        PHASE_BIT_45,
   input  wire logic        PHASE_BIT_90,
   input  wire logic        PHASE_BIT_MSB,
   output wire logic        SERIAL_DATA_OUT,
   output psc_phase_t       PHASE_STATE,
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY
);

   psc_pins_t     pin_meta;
   psc_pins_t     pin_sync;
   psc_phase_t    link_word;
   psc_phase_t    word_meta;
   psc_phase_t    word_sync;
   psc_phase_t    par_word;
   psc_phase_t    sw_phase;
   logic          le_prev;
   logic          serial_mode;
   logic          le_rise;
   logic          sw_override;
   logic          viol;
   logic [15:0]   latch_count;
   logic [7:0]    les_count;
   psc_wr_state_t wr_state;
   psc_rd_state_t rd_state;
   logic [7:0]    aw_addr;
   logic          aw_got;
   logic          w_got;
   logic [31:0]   w_data;
   logic [3:0]    w_strb;
   logic          do_write;
   logic [31:0]   next_rdata;
   logic [1:0]    next_rresp;
   logic [1:0]    next_bresp;

   // ---------------------------------------------------------------
   // Link side
   // ---------------------------------------------------------------
   psc_shift_link u_link (
      .shift_clk       (SHIFT_CLK_OR_PHASE_BIT_11P25),
      .rst             (RESET),
      .serial_mode     (PAR_SER_SEL),
      .latch_strobe    (LATCH_STROBE_OR_PHASE_BIT_22P5),
      .serial_data_in  (SERIAL_DATA_IN_OR_PHASE_BIT_LSB),
      .shift_word      (link_word),
      .serial_data_out (SERIAL_DATA_OUT)
   );

   // ---------------------------------------------------------------
   // Synchronisers
   // ---------------------------------------------------------------
   // Word is frozen while the strobe is high, so a plain two-stage
   // copy sampled alongside the strobe is coherent at its edge
   always_ff @(posedge SYS_CLK) begin
      pin_meta  <= {PAR_SER_SEL, PHASE_BIT_MSB, PHASE_BIT_90, PHASE_BIT_45,
                    LATCH_STROBE_OR_PHASE_BIT_22P5, SHIFT_CLK_OR_PHASE_BIT_11P25,
                    SERIAL_DATA_IN_OR_PHASE_BIT_LSB};
      pin_sync  <= pin_meta;
      word_meta <= link_word;
      word_sync <= word_meta;
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         le_prev <= 1'h1;
      end else begin
         le_prev <= pin_sync.le_b3;
      end
   end

   assign serial_mode = pin_sync.sel;
   assign le_rise     = serial_mode & pin_sync.le_b3 & ~le_prev;
   // Bit 5 carries 180 degrees down to bit 0 at one step
   assign par_word    = {pin_sync.b180, pin_sync.b90, pin_sync.b45,
                         pin_sync.le_b3, pin_sync.clk_b2, pin_sync.sdi_b1};

   // ---------------------------------------------------------------
   // Applied phase
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         PHASE_STATE <= `PSC_PHASE_RST;
      end else if (sw_override) begin
         PHASE_STATE <= sw_phase;
      end else if (!serial_mode) begin
         PHASE_STATE <= par_word;
      end else if (le_rise) begin
         PHASE_STATE <= word_sync;
      end
      // Otherwise hold, also across a switch into serial mode
   end

   // ---------------------------------------------------------------
   // Latch statistics and spacing check
   // ---------------------------------------------------------------
   // Spacing is measured after synchronisation, so it may be off by
   // one system cycle either way
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         les_count <= 8'(`PSC_LES_CYCLES);
      end else if (le_rise) begin
         les_count <= 8'h00;
      end else if (les_count < 8'(`PSC_LES_CYCLES)) begin
         les_count <= les_count + 8'h01;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         latch_count <= 16'h0000;
      end else if (le_rise) begin
         latch_count <= latch_count + 16'h0001;
      end
   end

   // New violation beats a clear in the same cycle
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         viol <= 1'h0;
      end else if (le_rise && les_count < 8'(`PSC_LES_CYCLES)) begin
         viol <= 1'h1;
      end else if (do_write && aw_addr == `PSC_ADDR_STATUS && w_strb[2] &&
                   w_data[`PSC_STAT_VIOL_BIT]) begin
         viol <= 1'h0;
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   assign do_write = (wr_state == PSC_WR_COLLECT) & aw_got & w_got;

   always_comb begin
      if (aw_addr == `PSC_ADDR_CTRL || aw_addr == `PSC_ADDR_SW_PHASE ||
          aw_addr == `PSC_ADDR_STATUS || aw_addr == `PSC_ADDR_LATCH_COUNT) begin
         next_bresp = `PSC_RESP_OKAY;
      end else begin
         next_bresp = `PSC_RESP_SLVERR;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         wr_state <= PSC_WR_COLLECT;
         aw_got   <= 1'h0;
         w_got    <= 1'h0;
         aw_addr  <= 8'h00;
         w_data   <= 32'h00000000;
         w_strb   <= 4'h0;
         AWREADY  <= 1'h1;
         WREADY   <= 1'h1;
         BVALID   <= 1'h0;
         BRESP    <= `PSC_RESP_OKAY;
      end else begin
         case (wr_state)
            PSC_WR_COLLECT: begin
               if (AWVALID && AWREADY) begin
                  aw_addr <= AWADDR;
                  aw_got  <= 1'h1;
                  AWREADY <= 1'h0;
               end
               if (WVALID && WREADY) begin
                  w_data <= WDATA;
                  w_strb <= WSTRB;
                  w_got  <= 1'h1;
                  WREADY <= 1'h0;
               end
               if (do_write) begin
                  aw_got   <= 1'h0;
                  w_got    <= 1'h0;
                  BVALID   <= 1'h1;
                  BRESP    <= next_bresp;
                  wr_state <= PSC_WR_RESP;
               end
            end
            PSC_WR_RESP: begin
               if (BREADY) begin
                  BVALID   <= 1'h0;
                  AWREADY  <= 1'h1;
                  WREADY   <= 1'h1;
                  wr_state <= PSC_WR_COLLECT;
               end
            end
            default: wr_state <= PSC_WR_COLLECT;
         endcase
      end
   end

   // Byte lane 0 holds the control fields; lane 2 of STATUS clears the violation flag
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         sw_override <= `PSC_CTRL_OVR_RST;
         sw_phase    <= `PSC_SW_PHASE_RST;
      end else if (do_write && w_strb[0]) begin
         if (aw_addr == `PSC_ADDR_CTRL) begin
            sw_override <= w_data[`PSC_CTRL_OVR_BIT];
         end else if (aw_addr == `PSC_ADDR_SW_PHASE) begin
            sw_phase <= w_data[5:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   always_comb begin
      next_rdata = 32'h00000000;
      next_rresp = `PSC_RESP_OKAY;
      if (ARADDR == `PSC_ADDR_CTRL) begin
         next_rdata[`PSC_CTRL_OVR_BIT] = sw_override;
      end else if (ARADDR == `PSC_ADDR_SW_PHASE) begin
         next_rdata[5:0] = sw_phase;
      end else if (ARADDR == `PSC_ADDR_STATUS) begin
         next_rdata[5:0]                = PHASE_STATE;
         next_rdata[`PSC_STAT_MODE_BIT] = serial_mode;
         next_rdata[`PSC_STAT_LE_BIT]   = pin_sync.le_b3;
         next_rdata[`PSC_STAT_VIOL_BIT] = viol;
      end else if (ARADDR == `PSC_ADDR_LATCH_COUNT) begin
         next_rdata[15:0] = latch_count;
      end else begin
         next_rresp = `PSC_RESP_SLVERR;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         rd_state <= PSC_RD_IDLE;
         ARREADY  <= 1'h1;
         RVALID   <= 1'h0;
         RDATA    <= 32'h00000000;
         RRESP    <= `PSC_RESP_OKAY;
      end else begin
         case (rd_state)
            PSC_RD_IDLE: begin
               if (ARVALID) begin
                  ARREADY  <= 1'h0;
                  RVALID   <= 1'h1;
                  RDATA    <= next_rdata;
                  RRESP    <= next_rresp;
                  rd_state <= PSC_RD_RESP;
               end
            end
            PSC_RD_RESP: begin
               if (RREADY) begin
                  RVALID   <= 1'h0;
                  ARREADY  <= 1'h1;
                  rd_state <= PSC_RD_IDLE;
               end
            end
            default: rd_state <= PSC_RD_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);

   sequence s_latch;
      le_rise && !sw_override;
   endsequence

   sequence s_quiet_serial;
      serial_mode && !le_rise && !sw_override;
   endsequence

   AST_LATCH_COMMIT: assert property (s_latch |=>
      PHASE_STATE == $past(word_sync))
      else $error("strobe edge did not commit word");

   AST_HOLD_LE_LOW: assert property (s_quiet_serial |=>
      $stable(PHASE_STATE))
      else $error("phase moved without strobe edge");

   AST_MODE_SWITCH: assert property (($rose(serial_mode) ##0 s_quiet_serial) |=>
      PHASE_STATE == $past(PHASE_STATE, 1))
      else $error("phase lost on entry to serial mode");

   AST_PARALLEL_FOLLOW: assert property ((!serial_mode && !sw_override) |=>
      PHASE_STATE == $past(par_word))
      else $error("parallel inputs not applied");

   AST_SHARED_LOW_BITS: assert property ((!serial_mode && !sw_override) |=>
      PHASE_STATE[2:0] == $past({pin_sync.le_b3, pin_sync.clk_b2, pin_sync.sdi_b1}))
      else $error("shared pins not used as low bits");

   AST_MSB_WEIGHT: assert property ((!serial_mode && !sw_override) |=>
      PHASE_STATE[5] == $past(pin_sync.b180, 1))
      else $error("top bit not mapped to top control input");

   AST_WRITE_RESP: assert property ((aw_got && w_got && !BVALID) |=>
      BVALID ##0 (AWREADY == 1'h0))
      else $error("write response missing");

endmodule

`default_nettype wire

/* hdl/psc_pkg.sv */
/*
 Types shared by the phase shifter control port modules.
 Assumes psc_regs.svh is on the include path.
*/
package psc_pkg;

   typedef logic [5:0] psc_phase_t;

   // Control pins, shared and dedicated, as seen after synchronisation
   typedef struct packed {
      logic sel;
      logic b180;
      logic b90;
      logic b45;
      logic le_b3;
      logic clk_b2;
      logic sdi_b1;
   } psc_pins_t;

   typedef enum {PSC_WR_COLLECT, PSC_WR_RESP} psc_wr_state_t;
   typedef enum {PSC_RD_IDLE, PSC_RD_RESP} psc_rd_state_t;

endpackage

/* hdl/psc_regs.svh */
/*
 Register offsets, field positions, reset values and timing counts
 of the phase shifter control port. Assumes a 200 MHz system clock.
*/
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define PSC_ADDR_CTRL        8'h00
`define PSC_ADDR_SW_PHASE    8'h04
`define PSC_ADDR_STATUS      8'h08
`define PSC_ADDR_LATCH_COUNT 8'h0C

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PSC_CTRL_OVR_BIT     0
`define PSC_STAT_MODE_BIT    8
`define PSC_STAT_LE_BIT      9
`define PSC_STAT_VIOL_BIT    16
`define PSC_CTRL_OVR_RST     1'h0
`define PSC_SW_PHASE_RST     6'h00
`define PSC_PHASE_RST        6'h00
`define PSC_RESP_OKAY        2'h0
`define PSC_RESP_SLVERR      2'h2

// ----------------------------------------------------------------
// Phase code and timing
// ----------------------------------------------------------------
`define PSC_PHASE_W          6
`define PSC_STEP_MILLIDEG    5625
`define PSC_SERIAL_DELAY     6
`define PSC_SYS_PERIOD_PS    5000
`define PSC_T_LES_NS         630
`define PSC_LES_CYCLES \
   ((`PSC_T_LES_NS * 1000 + `PSC_SYS_PERIOD_PS - 1) / `PSC_SYS_PERIOD_PS)

`endif

/* hdl/psc_shift_link.sv */
/*
 Serial shift path, clocked by the controller's shift clock.
 Assumes latch strobe, mode select and data come from the same
 controller as the shift clock and meet its set-up and hold.
*/
`timescale 1ns/1ps
`default_nettype none

module psc_shift_link
   import psc_pkg::*;
(
   input  wire logic       shift_clk,
   input  wire logic       rst,
   input  wire logic       serial_mode,
   input  wire logic       latch_strobe,
   input  wire logic       serial_data_in,
   output psc_phase_t      shift_word,
   output logic            serial_data_out
);

   logic shift_en;

   // ---------------------------------------------------------------
   // Shift register
   // ---------------------------------------------------------------
   // Masked in parallel mode and while the strobe is high
   assign shift_en = serial_mode & ~latch_strobe;

   // Clock may be idle at reset, so reset acts without it
   always_ff @(posedge shift_clk or posedge rst) begin
      if (rst) begin
         shift_word <= `PSC_PHASE_RST;
      end else if (shift_en) begin
         shift_word <= {shift_word[4:0], serial_data_in};
      end
   end

   // Oldest stage leaves six edges after entry
   always_ff @(posedge shift_clk or posedge rst) begin
      if (rst) begin
         serial_data_out <= 1'h0;
      end else if (shift_en) begin
         serial_data_out <= shift_word[4];
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge shift_clk); endclocking
   default disable iff (rst);

   sequence s_six_shifts;
      shift_en [*6];
   endsequence

   AST_SHIFT_FROZEN: assert property (latch_strobe |=> $stable(shift_word))
      else $error("shift word moved while strobe high");

   AST_SERIAL_DATA_OUT_DELAY: assert property (s_six_shifts |=>
      serial_data_out == $past(serial_data_in, 6))
      else $error("serial out not input delayed six edges");

   AST_MSB_FIRST: assert property (shift_en |=>
      shift_word[0] == $past(serial_data_in) &&
      shift_word[5:1] == $past(shift_word[4:0]))
      else $error("shift order wrong");

endmodule

`default_nettype wire

/* tb/psc_host_model.sv */
/*
 Behavioural host controller for the shared phase control pins.
 Assumes the bench calls one task at a time; the pins are push-pull.
*/
`timescale 1ns/1ps
`default_nettype none

module psc_host_model (
   output logic sel,
   output logic sdi_b1,
   output logic sclk_b2,
   output logic le_b3,
   output logic b45,
   output logic b90,
   output logic b180
);
   initial {sel, b180, b90, b45, le_b3, sclk_b2, sdi_b1} = 7'h00;

   task automatic set_par(input logic [5:0] c);
      {b180, b90, b45, le_b3, sclk_b2, sdi_b1} = c;
   endtask

   // Long settle so the select synchroniser has landed
   task automatic set_mode(input logic s);
      sel = s;
      #1000;
   endtask

   // Shift clock only runs inside a frame, 160 ns period
   task automatic load(input logic [15:0] w, input int n);
      // Off the system clock grid, so the two clocks stay unrelated
      #1.7;
      for (int i = n - 1; i >= 0; i--) begin
         sdi_b1 = w[i];
         #80 sclk_b2 = 1'b1;
         #80 sclk_b2 = 1'b0;
      end
      sdi_b1 = ~sdi_b1;
   endtask

   // Optional clock edges inside the pulse must be masked by the device
   task automatic strobe(input int edges);
      #40 le_b3 = 1'b1;
      for (int i = 0; i < edges; i++) begin
         #40 sdi_b1 = ~sdi_b1;
         #40 sclk_b2 = 1'b1;
         #40 sclk_b2 = 1'b0;
      end
      #200 le_b3 = 1'b0;
      #640;
   endtask
endmodule

`default_nettype wire

/* tb/tb.sv */
/*
 Self-checking bench for the phase shifter control port.
 Assumes psc_pkg and psc_regs.svh are compiled and on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.svh"

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb
   import psc_pkg::*;
;
   logic        sys_clk, reset, sel, sdi, sclk, le, b45, b90, b180, sdo, sdo_exp;
   psc_phase_t  phase;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [5:0]  hist, exp_phase, code;
   logic        sdo_q[$];
   int          err_total, check_count, seed, latches;

   psc_host_model host (.sel(sel), .sdi_b1(sdi), .sclk_b2(sclk), .le_b3(le),
      .b45(b45), .b90(b90), .b180(b180));

   psc_phase_ctrl dut (.SYS_CLK(sys_clk), .RESET(reset), .PAR_SER_SEL(sel),
      .SERIAL_DATA_IN_OR_PHASE_BIT_LSB(sdi), .SHIFT_CLK_OR_PHASE_BIT_11P25(sclk),
      .LATCH_STROBE_OR_PHASE_BIT_22P5(le), .PHASE_BIT_45(b45), .PHASE_BIT_90(b90),
      .PHASE_BIT_MSB(b180), .SERIAL_DATA_OUT(sdo), .PHASE_STATE(phase),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
      .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
      .RREADY(rready));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // ------------------------------------------------------------
   // Reference model of the serial path
   // ------------------------------------------------------------
   // Non-shift edges (parallel, strobe high) must leave the output alone
   always @(posedge sclk) begin
      if (sel && !le) begin
         sdo_q.push_back(sdi);
         sdo_exp = sdo_q.pop_front();
         hist = {hist[4:0], sdi};
      end
      #20 `CHK(sdo, sdo_exp)
   end

   always @(posedge le) begin
      if (sel) begin
         exp_phase = hist;
      end
   end

   // ------------------------------------------------------------
   // Register bus master
   // ------------------------------------------------------------
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rready <= 1'b0;
      `CHK(rd, e)
      `CHK(rresp, er)
   endtask

   task automatic chk_phase;
      repeat (8) @(posedge sys_clk);
      `CHK(phase, exp_phase)
   endtask

   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      // About five times the expected run
      #100000;
      err_total++;
      tally_and_finish();
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      seed = 36;
      // Output trails the newest sample by five stages, next device sees six
      sdo_q = {1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      {sdo_exp, hist, exp_phase, latches, err_total, check_count} = '0;
      {reset, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hF};
      // Raised after time zero so the link's edge-triggered reset sees it
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      chk_phase();
      rd_chk(`PSC_ADDR_CTRL, 32'h0, `PSC_RESP_OKAY);
      rd_chk(`PSC_ADDR_SW_PHASE, 32'h0, `PSC_RESP_OKAY);
      rd_chk(8'h10, 32'h0, `PSC_RESP_SLVERR);
      axi_write(8'h10, 32'hFFFFFFFF);
      `CHK(resp, `PSC_RESP_SLVERR)
      axi_write(`PSC_ADDR_LATCH_COUNT, 32'h00001234);
      `CHK(resp, `PSC_RESP_OKAY)
      rd_chk(`PSC_ADDR_LATCH_COUNT, 32'h0, `PSC_RESP_OKAY);
      $display("Test reset_map done");
      // One-hot weights then random codes, last one leaves strobe pin low
      for (int i = 0; i < 13; i++) begin
         code = (i < 6) ? 6'h01 << i : 6'($random(seed));
         if (i == 12) code = 6'h39;
         host.set_par(code);
         exp_phase = code;
         chk_phase();
      end
      rd_chk(`PSC_ADDR_STATUS, 32'h00000039, `PSC_RESP_OKAY);
      $display("Test parallel done");
      host.set_mode(1'b1);
      chk_phase();
      for (int f = 0; f < 6; f++) begin
         host.load(16'($random(seed)), 6 + f % 4);
         chk_phase();
         host.strobe(0);
         latches++;
         chk_phase();
      end
      rd_chk(`PSC_ADDR_STATUS, 32'h100 | exp_phase, `PSC_RESP_OKAY);
      $display("Test serial done");
      // Clock edges during the pulse must not disturb the next commit
      host.load(16'($random(seed)), 6);
      host.strobe(4);
      latches++;
      chk_phase();
      host.strobe(0);
      latches++;
      chk_phase();
      rd_chk(`PSC_ADDR_LATCH_COUNT, 32'(latches), `PSC_RESP_OKAY);
      $display("Test frozen done");
      code = 6'($random(seed));
      axi_write(`PSC_ADDR_SW_PHASE, {26'h0, code});
      axi_write(`PSC_ADDR_CTRL, 32'h1);
      exp_phase = code;
      chk_phase();
      axi_write(`PSC_ADDR_CTRL, 32'h0);
      host.set_mode(1'b0);
      code = 6'($random(seed));
      host.set_par(code);
      exp_phase = code;
      chk_phase();
      $display("Test override done");
      tally_and_finish();
   end
endmodule

`default_nettype wire
